// [hw/clock_select.sv]
module clock_select
	import timer_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic run,
	input wire logic [2:0] sel,
	input wire logic ext_pin,
	input wire logic sub_clk,
	output logic tick
);
	logic [5:0] div_reg, div_next;
	logic ext_meta_reg, ext_sync_reg, ext_last_reg, sub_last_reg, tick_reg;
	logic ext_meta_next, ext_sync_next, ext_last_next, sub_last_next, tick_next;

	// prescaler stops while off to save power; pin edges resolved after the synchroniser, sub clock edges taken unsynchronised
	always_comb begin
		div_next = run ? div_reg + 6'h01 : 6'h00;
		ext_meta_next = ext_pin;
		ext_sync_next = ext_meta_reg;
		ext_last_next = ext_sync_reg;
		sub_last_next = sub_clk;
		case (sel)
			CK_SYS4: tick_next = (div_reg & DIV4_MASK) == DIV4_MASK;
			CK_SYS: tick_next = 1'b1;
			CK_H16: tick_next = (div_reg & DIV16_MASK) == DIV16_MASK;
			CK_H64: tick_next = div_reg == DIV64_MASK;
			CK_SUB0, CK_SUB1: tick_next = sub_clk & ~sub_last_reg;
			CK_EXT_RISE: tick_next = ext_sync_reg & ~ext_last_reg;
			CK_EXT_FALL: tick_next = ~ext_sync_reg & ext_last_reg;
			default: tick_next = 1'b0;
		endcase
		if (!run) begin
			tick_next = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			div_reg <= 6'h00;
			ext_meta_reg <= 1'b0;
			ext_sync_reg <= 1'b0;
			ext_last_reg <= 1'b0;
			sub_last_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else if (ce) begin
			div_reg <= div_next;
			ext_meta_reg <= ext_meta_next;
			ext_sync_reg <= ext_sync_next;
			ext_last_reg <= ext_last_next;
			sub_last_reg <= sub_last_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;
endmodule

// [hw/standard_timer.sv]
// What this block does
// - pause bit set stops counting, keeps value; clearing resumes from it
// - clock select: sys/4, sys, high/16, high/64, sub, external rise or fall
// - counter-on high runs the counter; low stops it and powers down
// - counter-on rising edge clears the 16-bit counter
// - counter-on falling edge holds counter value until set again
// - counter-on rising edge returns pin to initial level in output modes
// - low three bits of run control read as zero
// - mode field: compare output, undefined, PWM or single pulse, timer
// - timer mode parks pin low and ignores output function
// - compare mode A match: no change, low, high or toggle
// - PWM mode output: inactive, active, PWM waveform, single pulse
// - compare match low or high changes pin only if level differs from initial; toggle always changes it
// - output control bit: initial level, or active level in PWM
// - polarity bit inverts pin, except in timer and undefined modes
// - swap bit exchanges period and duty comparators in PWM
// - clear select high: A match clears; low: P match or overflow
// - overflow clearing only when compare P is zero, wraps at max
// - clear select ignored in PWM and single pulse modes
// - compare P matches counter high byte: period value times 256
// - compare A held in low and high bytes, reset zero
// - low byte goes through buffer latched by high-byte access
// - 16-bit up counter; comparator A compares all 16 bits
module standard_timer
	import timer_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic external_clock_pin,
	input wire logic low_speed_clock,
	output logic waveform_output_pin
);
	// register file state
	logic [7:0] run_reg, run_next;
	logic [7:0] mode_reg, mode_next;
	logic [15:0] ca_reg, ca_next;
	logic [7:0] cp_reg, cp_next;
	logic [7:0] ca_buf_reg, ca_buf_next;
	logic [7:0] cnt_buf_reg, cnt_buf_next;
	logic [31:0] dat_reg, dat_next;
	logic ack_reg, ack_next;

	// core state
	logic [15:0] cnt_reg, cnt_next;
	logic level_reg, level_next;
	logic pin_reg, pin_next;

	// decoded fields and events
	logic req, wr, rd, on_rise, sp_stop, tick, count_en, a_hit, p_hit, clr;
	logic [4:0] addr;
	logic [15:0] inc;
	logic [1:0] opm, io;
	logic pause, on, oc, pol, dpx, ccl, below;

	// duty threshold in counter units; zero compare P means a full 65536
	function automatic logic [16:0] p_span(input logic [7:0] p);
		p_span = (p == 8'h00) ? 17'h10000 : {1'b0, p, 8'h00};
	endfunction

	assign pause = run_reg[RUN_PAUSE_BIT];
	assign on = run_reg[RUN_ON_BIT];
	assign opm = mode_reg[MODE_M_LSB +: 2];
	assign io = mode_reg[MODE_IO_LSB +: 2];
	assign oc = mode_reg[MODE_OC_BIT];
	assign pol = mode_reg[MODE_POL_BIT];
	assign dpx = mode_reg[MODE_DPX_BIT];
	assign ccl = mode_reg[MODE_CCL_BIT];

	// count pulses from the selected source; prescaler idles while off
	clock_select u_clock_select (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.run(on),
		.sel(run_reg[RUN_CK_LSB +: 3]),
		.ext_pin(external_clock_pin),
		.sub_clk(low_speed_clock),
		.tick(tick)
	);

	// wishbone slave: one request per ack, answer registered one cycle later
	always_comb begin
		addr = {wb_adr_i[4:2], 2'b00};
		req = wb_cyc_i & wb_stb_i & ~ack_reg;
		wr = req & wb_we_i & wb_sel_i[0];
		rd = req & ~wb_we_i;
		run_next = run_reg;
		mode_next = mode_reg;
		ca_next = ca_reg;
		cp_next = cp_reg;
		ca_buf_next = ca_buf_reg;
		cnt_buf_next = cnt_buf_reg;
		ack_next = req;
		dat_next = 32'h0000_0000;
		on_rise = 1'b0;
		// pulse ends when comparator A matches in single pulse output
		if (sp_stop) begin
			run_next[RUN_ON_BIT] = 1'b0;
		end
		if (wr) begin
			case (addr)
				OFF_RUN: begin
					run_next = wb_dat_i[7:0] & RUN_MASK;
					on_rise = wb_dat_i[RUN_ON_BIT] & ~on;
				end
				OFF_MODE: mode_next = wb_dat_i[7:0];
				OFF_CA_LO: ca_buf_next = wb_dat_i[7:0];
				OFF_CA_HI: ca_next = {wb_dat_i[7:0], ca_buf_reg};
				OFF_CP: cp_next = wb_dat_i[7:0];
				default: ;
			endcase
		end
		if (rd) begin
			case (addr)
				OFF_RUN: dat_next = {24'h000000, run_reg & RUN_MASK};
				OFF_MODE: dat_next = {24'h000000, mode_reg};
				OFF_CNT_LO: dat_next = {24'h000000, cnt_buf_reg};
				OFF_CNT_HI: begin
					dat_next = {24'h000000, cnt_reg[15:8]};
					cnt_buf_next = cnt_reg[7:0];
				end
				OFF_CA_LO: dat_next = {24'h000000, ca_buf_reg};
				OFF_CA_HI: begin
					dat_next = {24'h000000, ca_reg[15:8]};
					ca_buf_next = ca_reg[7:0];
				end
				OFF_CP: dat_next = {24'h000000, cp_reg};
				default: dat_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			run_reg <= RST_BYTE;
			mode_reg <= RST_BYTE;
			ca_reg <= RST_WORD;
			cp_reg <= RST_BYTE;
			ca_buf_reg <= RST_BYTE;
			cnt_buf_reg <= RST_BYTE;
			dat_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
		end else if (ce) begin
			run_reg <= run_next;
			mode_reg <= mode_next;
			ca_reg <= ca_next;
			cp_reg <= cp_next;
			ca_buf_reg <= ca_buf_next;
			cnt_buf_reg <= cnt_buf_next;
			dat_reg <= dat_next;
			ack_reg <= ack_next;
		end
	end

	// counter, comparators and output level
	always_comb begin
		count_en = on & ~pause & tick;
		inc = cnt_reg + 16'h0001;
		a_hit = count_en && (inc == ca_reg) && (ca_reg != RST_WORD);
		p_hit = count_en && (cp_reg != RST_BYTE) && (inc == {cp_reg, 8'h00});
		// PWM picks the period comparator by the swap bit, not clear select
		if (opm == OPM_PWM) begin
			clr = dpx ? a_hit : p_hit;
		end else begin
			clr = ccl ? a_hit : p_hit;
		end
		if (on_rise) begin
			cnt_next = RST_WORD;
		end else if (count_en) begin
			cnt_next = clr ? RST_WORD : inc;
		end else begin
			cnt_next = cnt_reg;
		end
		// duty comparison against the counter value about to be shown
		if (dpx) begin
			below = {1'b0, cnt_next} < p_span(cp_reg);
		end else begin
			below = {1'b0, cnt_next} < {1'b0, ca_reg};
		end
		sp_stop = (opm == OPM_PWM) && (io == IO_D) && a_hit;
		level_next = level_reg;
		case (opm)
			OPM_CMP: begin
				if (on_rise) begin
					level_next = oc;
				end else if (a_hit) begin
					case (io)
						IO_B: level_next = oc ? 1'b0 : level_reg;
						IO_C: level_next = oc ? level_reg : 1'b1;
						IO_D: level_next = ~level_reg;
						default: level_next = level_reg;
					endcase
				end
			end
			OPM_PWM: begin
				case (io)
					IO_A: level_next = ~oc;
					IO_B: level_next = oc;
					IO_C: level_next = (on_rise || (on && below)) ? oc : ~oc;
					IO_D: level_next = ((on || on_rise) && !sp_stop) ? oc : ~oc;
					default: level_next = level_reg;
				endcase
			end
			default: level_next = level_reg;
		endcase
		// timer mode and undefined mode leave the pin parked low
		if (opm == OPM_TMR || opm == 2'h1) begin
			pin_next = 1'b0;
		end else begin
			pin_next = level_next ^ pol;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			cnt_reg <= RST_WORD;
			level_reg <= 1'b0;
			pin_reg <= 1'b0;
		end else if (ce) begin
			cnt_reg <= cnt_next;
			level_reg <= level_next;
			pin_reg <= pin_next;
		end
	end

	assign wb_dat_o = dat_reg;
	assign wb_ack_o = ack_reg;
	assign waveform_output_pin = pin_reg;

	// checks on the core and bus behaviour
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn || !ce);

	property p_pause_hold;
		on && pause && !on_rise |=> cnt_reg == $past(cnt_reg);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("counter moved while paused");

	property p_on_clear;
		on_rise ##1 ce |-> cnt_reg == 16'h0000;
	endproperty
	a_on_clear: assert property (p_on_clear) else $error("counter not cleared on enable");

	property p_off_hold;
		!on && !on_rise |=> $stable(cnt_reg);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("counter moved while off");

	property p_unimpl;
		wb_ack_o && !wb_we_i && {wb_adr_i[4:2], 2'b00} == OFF_RUN |-> wb_dat_o[2:0] == 3'h0;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("reserved run bits read nonzero");

	property p_init_level;
		on_rise && opm == OPM_CMP |=> level_reg == $past(oc);
	endproperty
	a_init_level: assert property (p_init_level) else $error("initial level not restored");

	property p_toggle;
		opm == OPM_CMP && io == IO_D && a_hit && !on_rise |=> level_reg != $past(level_reg);
	endproperty
	a_toggle: assert property (p_toggle) else $error("compare toggle missed");

	property p_a_clear;
		opm == OPM_CMP && ccl && a_hit && !on_rise |=> cnt_reg == 16'h0000;
	endproperty
	a_a_clear: assert property (p_a_clear) else $error("A match did not clear");

	// the clear lands on the count that would reach the P boundary, not past it
	property p_p_period;
		opm == OPM_CMP && !ccl && count_en && !on_rise && cp_reg != 8'h00
			&& (cnt_reg + 16'h0001) == {cp_reg, 8'h00} |=> cnt_reg == 16'h0000;
	endproperty
	a_p_period: assert property (p_p_period) else $error("P period not honoured");

	property p_hi_latch;
		wr && addr == OFF_CA_HI |=> ca_reg == {$past(wb_dat_i[7:0]), $past(ca_buf_reg)};
	endproperty
	a_hi_latch: assert property (p_hi_latch) else $error("compare A latch wrong");

	property p_timer_pin;
		opm == OPM_TMR |=> waveform_output_pin == 1'b0;
	endproperty
	a_timer_pin: assert property (p_timer_pin) else $error("pin active in timer mode");
endmodule

// [hw/timer_pkg.sv]
package timer_pkg;
	// byte offsets of the word-aligned registers
	localparam logic [4:0] OFF_RUN = 5'h00;
	localparam logic [4:0] OFF_MODE = 5'h04;
	localparam logic [4:0] OFF_CNT_LO = 5'h08;
	localparam logic [4:0] OFF_CNT_HI = 5'h0C;
	localparam logic [4:0] OFF_CA_LO = 5'h10;
	localparam logic [4:0] OFF_CA_HI = 5'h14;
	localparam logic [4:0] OFF_CP = 5'h18;

	// timer_run_control fields
	localparam int RUN_PAUSE_BIT = 7;
	localparam int RUN_CK_LSB = 4;
	localparam int RUN_ON_BIT = 3;
	localparam logic [7:0] RUN_MASK = 8'hF8;

	// timer_mode_control fields
	localparam int MODE_M_LSB = 6;
	localparam int MODE_IO_LSB = 4;
	localparam int MODE_OC_BIT = 3;
	localparam int MODE_POL_BIT = 2;
	localparam int MODE_DPX_BIT = 1;
	localparam int MODE_CCL_BIT = 0;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	// operating modes
	localparam logic [1:0] OPM_CMP = 2'h0;
	localparam logic [1:0] OPM_PWM = 2'h2;
	localparam logic [1:0] OPM_TMR = 2'h3;

	// output function codes
	localparam logic [1:0] IO_A = 2'h0;
	localparam logic [1:0] IO_B = 2'h1;
	localparam logic [1:0] IO_C = 2'h2;
	localparam logic [1:0] IO_D = 2'h3;

	// clock source codes
	localparam logic [2:0] CK_SYS4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_H16 = 3'h2;
	localparam logic [2:0] CK_H64 = 3'h3;
	localparam logic [2:0] CK_SUB0 = 3'h4;
	localparam logic [2:0] CK_SUB1 = 3'h5;
	localparam logic [2:0] CK_EXT_RISE = 3'h6;
	localparam logic [2:0] CK_EXT_FALL = 3'h7;

	// prescaler terminal counts (divide by 4, 16, 64)
	localparam logic [5:0] DIV4_MASK = 6'h03;
	localparam logic [5:0] DIV16_MASK = 6'h0F;
	localparam logic [5:0] DIV64_MASK = 6'h3F;
endpackage

// [verification/ext_pins.sv]
module ext_pins (
	input wire logic mclk,
	output logic external_clock_pin,
	output logic low_speed_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	int div = 0;
	// count pin idles low between bursts
	initial begin
		external_clock_pin = 1'h0;
		low_speed_clock = 1'h0;
	end
	// sub clock runs free at a sixteenth of mclk
	always @(posedge mclk) begin
		div <= div + 1;
		if (div % 8 == 7) begin
			low_speed_clock <= ~low_speed_clock;
		end
	end
	// n slow pulses, wide enough for the pin synchroniser
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge mclk);
			external_clock_pin <= 1'h1;
			repeat (4) @(posedge mclk);
			external_clock_pin <= 1'h0;
			repeat (3) @(posedge mclk);
		end
	endtask
endmodule

// [verification/standard_timer_tb.sv]
module standard_timer_tb
	import timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'h0;
	logic rstn = 1'h0;
	logic ce_drv = 1'h1;
	logic cyc = 1'h0;
	logic we = 1'h0;
	logic [4:0] adr = 5'h00;
	logic [7:0] dat = 8'h00;
	logic [31:0] rdat;
	logic ack;
	logic ext_pin;
	logic sub_clk;
	logic pin;
	int miscompares = 0;
	int total_checks = 0;
	// 50 MHz system clock
	always #10 mclk = ~mclk;
	// strobe follows cycle: one request per cycle window
	standard_timer dut_u (.mclk(mclk), .rstn(rstn), .ce(ce_drv), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i({24'h000000, dat}),
		.wb_dat_o(rdat), .wb_ack_o(ack), .external_clock_pin(ext_pin),
		.low_speed_clock(sub_clk), .waveform_output_pin(pin));
	ext_pins far_u (.mclk(mclk), .external_clock_pin(ext_pin), .low_speed_clock(sub_clk));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	function automatic logic near(input int v, input int e, input int t);
		return v >= e - t && v <= e + t;
	endfunction
	// one classic cycle, held until ack is sampled; a lost ack ends the run
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		output logic [7:0] q);
		int n = 0;
		@(posedge mclk);
		cyc <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'h1 && n < 20);
		if (ack !== 1'h1) begin
			miscompares++;
			complete_run();
		end
		q = rdat[7:0];
		cyc <= 1'h0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'h1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] q);
		bus(1'h0, a, 8'h00, q);
	endtask
	// high byte first so the low byte comes from the same snapshot
	task automatic cnt(output logic [15:0] v);
		rd(OFF_CNT_HI, v[15:8]);
		rd(OFF_CNT_LO, v[7:0]);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic duty(output int c);
		c = 0;
		repeat (256) begin
			@(posedge mclk);
			c += (pin === 1'h1);
		end
	endtask
	// timer off first, mode changes only while stopped
	task automatic setup(input logic [7:0] m, input logic [7:0] p, input logic [15:0] a);
		wr(OFF_RUN, 8'h00);
		wr(OFF_MODE, m);
		wr(OFF_CP, p);
		wr(OFF_CA_LO, a[7:0]);
		wr(OFF_CA_HI, a[15:8]);
	endtask
	task automatic t_regs();
		logic [7:0] q;
		logic [4:0] offs [6] = '{OFF_RUN, OFF_MODE, OFF_CA_LO, OFF_CA_HI, OFF_CP, 5'h1C};
		foreach (offs[i]) begin
			rd(offs[i], q);
			chk("reset value", q, 8'h00);
		end
		wr(OFF_RUN, 8'hF7);
		rd(OFF_RUN, q);
		chk("run control", q, 8'hF0);
		wr(5'h1C, 8'hA5);
		rd(5'h1C, q);
		chk("unmapped", q, 8'h00);
		$display("test registers done");
	endtask
	task automatic t_buf();
		logic [7:0] q;
		wr(OFF_CA_LO, 8'h34);
		wr(OFF_CA_HI, 8'h12);
		rd(OFF_CA_HI, q);
		chk("compare high", q, 8'h12);
		rd(OFF_CA_LO, q);
		chk("compare low", q, 8'h34);
		wr(OFF_CA_LO, 8'h56);
		rd(OFF_CA_HI, q);
		rd(OFF_CA_LO, q);
		chk("unlatched low", q, 8'h34);
		$display("test buffer done");
	endtask
	task automatic t_clk();
		int exp [6] = '{64, 256, 16, 4, 16, 16};
		logic [15:0] v;
		setup(8'hC0, 8'h00, 16'h0000);
		for (int k = 0; k < 8; k++) begin
			wr(OFF_RUN, 8'h00);
			wr(OFF_RUN, {1'h0, 3'(k), 4'h8});
			if (k < 6) begin
				idle(256);
				wr(OFF_RUN, {1'h1, 3'(k), 4'h8});
				cnt(v);
				chk("divided count", near(v, exp[k], 3), 1'h1);
			end else begin
				far_u.pulse(20);
				idle(8);
				cnt(v);
				chk("pin edges", v, 16'h0014);
			end
		end
		$display("test clock select done");
	endtask
	task automatic t_hold();
		logic [15:0] a;
		logic [15:0] b;
		setup(8'hC0, 8'h00, 16'h0000);
		wr(OFF_RUN, 8'h18);
		idle(40);
		wr(OFF_RUN, 8'h98);
		cnt(a);
		idle(20);
		cnt(b);
		chk("paused", b, a);
		wr(OFF_RUN, 8'h18);
		idle(20);
		cnt(b);
		chk("resumed", b > a && b < a + 16'h0020, 1'h1);
		wr(OFF_RUN, 8'h10);
		cnt(a);
		idle(20);
		cnt(b);
		chk("off holds", b, a);
		wr(OFF_RUN, 8'h18);
		cnt(b);
		chk("on clears", b < 16'h0010, 1'h1);
		$display("test hold done");
	endtask
	// every output function, initial level and polarity; A match every 16 counts
	task automatic t_cmp();
		logic [3:0] c;
		logic e;
		for (int k = 0; k < 16; k++) begin
			c = 4'(k);
			setup({2'h0, c[1:0], c[2], c[3], 2'h1}, 8'h00, 16'h0010);
			wr(OFF_RUN, 8'h18);
			idle(2);
			chk("initial level", pin, c[2] ^ c[3]);
			idle(22);
			e = c[1:0] == 2'h0 ? c[2] : c[1:0] == 2'h1 ? 1'h0 : c[1:0] == 2'h2 ? 1'h1 : ~c[2];
			chk("match level", pin, e ^ c[3]);
		end
		$display("test compare done");
	endtask
	// clear by P at 256 counts, or no clear with A selected and zero
	task automatic t_pclr();
		logic [7:0] m [2] = '{8'hC0, 8'hC1};
		int exp [2] = '{45, 301};
		logic [15:0] v;
		foreach (m[i]) begin
			setup(m[i], 8'h01, 16'h0000);
			wr(OFF_RUN, 8'h18);
			idle(300);
			wr(OFF_RUN, 8'h98);
			cnt(v);
			chk("clear source", near(v, exp[i], 4), 1'h1);
		end
		$display("test clear done");
	endtask
	// high cycles per 256: waveform, swap, ignored clear select, forced levels
	task automatic t_pwm();
		logic [7:0] m [7] = '{8'hA8, 8'hA9, 8'hAA, 8'h88, 8'h98, 8'h8C, 8'hC8};
		int exp [7] = '{64, 64, 256, 0, 256, 256, 0};
		int c;
		foreach (m[i]) begin
			setup(m[i], 8'h01, 16'h0040);
			wr(OFF_RUN, 8'h18);
			idle(4);
			duty(c);
			chk("high cycles", near(c, exp[i], 2), 1'h1);
		end
		$display("test pwm done");
	endtask
	task automatic t_pulse();
		logic [7:0] q;
		setup(8'hB8, 8'h00, 16'h0020);
		wr(OFF_RUN, 8'h18);
		idle(4);
		chk("pulse active", pin, 1'h1);
		idle(60);
		chk("pulse ended", pin, 1'h0);
		rd(OFF_RUN, q);
		chk("on bit cleared", q[3], 1'h0);
		$display("test single pulse done");
	endtask
	// clock enable low must freeze the running counter
	task automatic t_freeze();
		logic [15:0] a;
		setup(8'hC0, 8'h00, 16'h0000);
		wr(OFF_RUN, 8'h18);
		@(posedge mclk);
		ce_drv <= 1'h0;
		idle(40);
		ce_drv <= 1'h1;
		wr(OFF_RUN, 8'h98);
		cnt(a);
		chk("frozen count", a < 16'h0008, 1'h1);
		$display("test clock enable done");
	endtask
	// reset for three edges, then every scenario in turn
	initial begin
		repeat (3) @(posedge mclk);
		rstn <= 1'h1;
		t_regs();
		t_buf();
		t_clk();
		t_hold();
		t_cmp();
		t_pclr();
		t_pwm();
		t_pulse();
		t_freeze();
		complete_run();
	end
endmodule
